// ===== hdl/cpc_capture.sv
// How it works
// - width field picks 8/10/12/14 sampled bits
// - embedded mode uses eight data lines only
// - each source gated by its enable bit
// - hardware mode: four sources; embedded adds error
// - sticky raw flag per interrupt source
// - sample on chosen pixel clock edge
// - sync source bit: clear means hardware sync
// - separate polarity for line and frame sync
// - hardware frame sync interrupt even without capture
// - embedded codes only with 8-bit data
// - code register: fec, lec, lsc, fsc bytes
// - frame flag clears on end, sets on start
// - fec of ff matches all unused codes
// - lsc of ff: first line starts frame
// - polarities ignored in embedded mode
// - status shows line and frame active
// - out-of-order codes raise error interrupt
// - continuous and single-frame snapshot capture
// - captured words offered to system dma
// - global interrupt is or of masked sources
// - masked status register reads raw and enable
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cpc_capture (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic pixel_clock_in,
    input wire logic [cpc_pkg::CPC_DATA_W-1:0] data_in,
    input wire logic line_sync_in,
    input wire logic frame_sync_in,
    input wire logic [cpc_pkg::CPC_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic dma_ack_in,
    output logic dma_req_out,
    output logic [31:0] dma_word_out,
    output logic camera_global_irq_out
);
    import cpc_pkg::*;

    typedef struct packed {
        logic capture;
        logic snapshot;
        logic sync_source_select;
        logic sample_edge_select;
        logic line_sync_polarity;
        logic frame_sync_polarity;
        logic [1:0] extended_width_select;
        logic enable;
        logic [CPC_IRQ_N-1:0] ier;
        logic [CPC_IRQ_N-1:0] ris;
        logic [31:0] codes;
        logic [31:0] rdata;
        logic irq;
        logic [31:0] dma_word;
        logic dma_req;
        logic line_act;
        logic frame_act;
        logic cap_frame;
        logic [31:0] pack;
        logic [1:0] pack_idx;
        logic pclk_prev;
    } cpc_state_t;

    cpc_state_t st_reg;
    cpc_state_t st_next;

    logic [CPC_SYNC_W-1:0] sync_vec;
    logic pclk_s;
    logic line_s;
    logic frame_s;
    logic [CPC_DATA_W-1:0] data_s;
    logic edge_hit;
    logic embedded;
    logic code_hit;
    logic [7:0] code;
    logic mk_pv;
    logic [7:0] mk_pix;
    logic [7:0] fec;
    logic [7:0] line_end_code;
    logic [7:0] line_start_code;
    logic [7:0] frame_start_code;
    logic is_fec;
    logic is_lec;
    logic is_lsc;
    logic is_fsc;
    logic [CPC_IRQ_N-1:0] mis;
    logic mis_any;

    cpc_sync3 #(
        .W(CPC_SYNC_W)
    ) u_sync (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .async_in({pixel_clock_in, line_sync_in, frame_sync_in, data_in}),
        .stable_out(sync_vec)
    );

    assign pclk_s = sync_vec[CPC_SYNC_W-1];
    assign line_s = sync_vec[CPC_SYNC_W-2];
    assign frame_s = sync_vec[CPC_SYNC_W-3];
    assign data_s = sync_vec[CPC_DATA_W-1:0];
    assign embedded = st_reg.sync_source_select;
    // edge polarity picks rising or falling
    assign edge_hit = (pclk_s != st_reg.pclk_prev)
        && (pclk_s == st_reg.sample_edge_select);

    // markers come from the low byte only
    cpc_marker u_marker (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .byte_in(data_s[7:0]),
        .strobe_in(edge_hit && embedded && st_reg.enable),
        .code_hit_out(code_hit),
        .code_out(code),
        .pix_valid_out(mk_pv),
        .pix_out(mk_pix)
    );

    // code bytes from the code register
    assign fec = st_reg.codes[CPC_FEC_LSB +: 8];
    assign line_end_code = st_reg.codes[CPC_LEC_LSB +: 8];
    assign line_start_code = st_reg.codes[CPC_LSC_LSB +: 8];
    assign frame_start_code = st_reg.codes[CPC_FSC_LSB +: 8];
    // wildcard frame end takes unused codes
    assign is_fec = code_hit && ((code == fec) || ((fec == CPC_CODE_WILD)
        && (code != line_end_code) && (code != line_start_code) && (code != frame_start_code)));
    assign is_lec = code_hit && (code == line_end_code);
    assign is_lsc = code_hit && (code == line_start_code);
    assign is_fsc = code_hit && (code == frame_start_code);
    assign mis = st_reg.ris & st_reg.ier;
    assign mis_any = |mis;

    always_comb begin
        logic [CPC_IRQ_N-1:0] ev;
        logic [13:0] sample;
        logic pix;
        logic byte_mode;
        logic full;
        logic line_lvl;
        logic frame_lvl;
        logic [31:0] word;
        ev = '0;
        sample = '0;
        pix = 1'b0;
        full = 1'b0;
        word = st_reg.pack;
        // each sync line has its own level
        line_lvl = (line_s == st_reg.line_sync_polarity);
        frame_lvl = (frame_s == st_reg.frame_sync_polarity);
        byte_mode = embedded || (st_reg.extended_width_select == CPC_W8);
        st_next = st_reg;
        st_next.pclk_prev = pclk_s;
        st_next.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                CPC_OFS_CTRL: begin
                    st_next.rdata[CPC_CTRL_CAPTURE] = st_reg.capture;
                    st_next.rdata[CPC_CTRL_SNAPSHOT] = st_reg.snapshot;
                    st_next.rdata[CPC_CTRL_SYNC_SRC] = embedded;
                    st_next.rdata[CPC_CTRL_EDGE] = st_reg.sample_edge_select;
                    st_next.rdata[CPC_CTRL_LPOL] = st_reg.line_sync_polarity;
                    st_next.rdata[CPC_CTRL_FPOL] = st_reg.frame_sync_polarity;
                    st_next.rdata[CPC_CTRL_WIDTH +: 2] =
                        st_reg.extended_width_select;
                    st_next.rdata[CPC_CTRL_ENABLE] = st_reg.enable;
                end
                CPC_OFS_STATUS: begin
                    st_next.rdata[CPC_STAT_LINE] = st_reg.line_act;
                    st_next.rdata[CPC_STAT_FRAME] = st_reg.frame_act;
                    st_next.rdata[CPC_STAT_DMA] = st_reg.dma_req;
                end
                CPC_OFS_RIS: st_next.rdata[CPC_IRQ_N-1:0] = st_reg.ris;
                CPC_OFS_IER: st_next.rdata[CPC_IRQ_N-1:0] = st_reg.ier;
                CPC_OFS_MIS: st_next.rdata[CPC_IRQ_N-1:0] = mis;
                CPC_OFS_CODES: st_next.rdata = st_reg.codes;
                CPC_OFS_DATA: st_next.rdata = st_reg.dma_word;
                default: st_next.rdata = '0;
            endcase
        end
        if (wr_in) begin
            case (addr_in)
                CPC_OFS_CTRL: begin
                    st_next.capture = wdata_in[CPC_CTRL_CAPTURE];
                    st_next.snapshot = wdata_in[CPC_CTRL_SNAPSHOT];
                    st_next.sync_source_select = wdata_in[CPC_CTRL_SYNC_SRC];
                    st_next.sample_edge_select = wdata_in[CPC_CTRL_EDGE];
                    st_next.line_sync_polarity = wdata_in[CPC_CTRL_LPOL];
                    st_next.frame_sync_polarity = wdata_in[CPC_CTRL_FPOL];
                    st_next.extended_width_select =
                        wdata_in[CPC_CTRL_WIDTH +: 2];
                    st_next.enable = wdata_in[CPC_CTRL_ENABLE];
                end
                CPC_OFS_IER: st_next.ier = wdata_in[CPC_IRQ_N-1:0];
                // write one to clear; a same-cycle event wins below
                CPC_OFS_ICR: st_next.ris = st_reg.ris
                    & ~wdata_in[CPC_IRQ_N-1:0];
                CPC_OFS_CODES: st_next.codes = wdata_in;
                default: st_next.codes = st_reg.codes;
            endcase
        end
        // sample width from the width field
        case (st_reg.extended_width_select)
            CPC_W8: sample = data_s & CPC_MASK8;
            CPC_W10: sample = data_s & CPC_MASK10;
            CPC_W12: sample = data_s & CPC_MASK12;
            default: sample = data_s & CPC_MASK14;
        endcase
        if (!embedded) begin
            // polarities only matter in this branch
            st_next.line_act = line_lvl;
            st_next.frame_act = frame_lvl;
            if (frame_lvl && !st_reg.frame_act) begin
                // frame sync flagged even while idle
                ev[CPC_IRQ_FSYNC] = 1'b1;
                st_next.cap_frame = st_reg.capture && st_reg.enable;
                st_next.pack_idx = '0;
            end
            if (!frame_lvl && st_reg.frame_act && st_reg.cap_frame) begin
                ev[CPC_IRQ_FRAME] = 1'b1;
                st_next.cap_frame = 1'b0;
                if (st_reg.snapshot) begin
                    st_next.capture = 1'b0;
                end
            end
            if (!line_lvl && st_reg.line_act && st_reg.cap_frame) begin
                ev[CPC_IRQ_LINE] = 1'b1;
            end
            // hardware mode samples on the edge
            pix = edge_hit && line_lvl && frame_lvl && st_reg.cap_frame;
        end else begin
            pix = mk_pv && st_reg.line_act && st_reg.frame_act
                && st_reg.cap_frame;
            sample = {6'h00, mk_pix};
            if (is_fec) begin
                // frame flag drops on frame end
                ev[CPC_IRQ_ERR] = !st_reg.frame_act;
                st_next.frame_act = 1'b0;
                st_next.line_act = 1'b0;
                if (st_reg.cap_frame) begin
                    ev[CPC_IRQ_FRAME] = 1'b1;
                    st_next.cap_frame = 1'b0;
                    if (st_reg.snapshot) begin
                        st_next.capture = 1'b0;
                    end
                end
            end else if (is_fsc || (is_lsc && (line_start_code == CPC_CODE_WILD)
                && !st_reg.frame_act)) begin
                // wildcard line start also opens frame
                ev[CPC_IRQ_ERR] = is_fsc && st_reg.frame_act;
                ev[CPC_IRQ_FSYNC] = 1'b1;
                st_next.frame_act = 1'b1;
                st_next.line_act = is_lsc;
                st_next.cap_frame = st_reg.capture && st_reg.enable;
                st_next.pack_idx = '0;
            end else if (is_lsc) begin
                // line start outside frame or inside line
                ev[CPC_IRQ_ERR] = !st_reg.frame_act || st_reg.line_act;
                st_next.line_act = 1'b1;
            end else if (is_lec) begin
                ev[CPC_IRQ_ERR] = !st_reg.line_act;
                st_next.line_act = 1'b0;
                ev[CPC_IRQ_LINE] = st_reg.cap_frame && st_reg.line_act;
            end
        end
        // pack samples into words for the dma
        if (pix) begin
            if (byte_mode) begin
                word[{st_reg.pack_idx, 3'h0} +: 8] = sample[7:0];
                full = (st_reg.pack_idx == CPC_BYTE_LAST);
            end else begin
                word[{st_reg.pack_idx[0], 4'h0} +: 16] = {2'h0, sample};
                full = st_reg.pack_idx[0];
            end
            st_next.pack = word;
            st_next.pack_idx = full ? 2'h0 : st_reg.pack_idx + 2'h1;
        end
        if (dma_ack_in) begin
            st_next.dma_req = 1'b0;
        end
        if (full) begin
            // word lost when the previous one is still unread
            if (st_reg.dma_req && !dma_ack_in) begin
                ev[CPC_IRQ_OVR] = 1'b1;
            end else begin
                st_next.dma_word = word;
                st_next.dma_req = 1'b1;
            end
        end
        // error source only in embedded mode
        ev[CPC_IRQ_ERR] = ev[CPC_IRQ_ERR] && embedded;
        st_next.ris = st_next.ris | ev;
        // global line is or of masked flags
        st_next.irq = mis_any;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_reg <= '0;
            st_reg.codes <= CPC_CODES_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_out = st_reg.rdata;
    assign dma_req_out = st_reg.dma_req;
    assign dma_word_out = st_reg.dma_word;
    assign camera_global_irq_out = st_reg.irq;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    logic frame_lvl_w;
    assign frame_lvl_w = (frame_s == st_reg.frame_sync_polarity);

    sequence s_snap_end;
        st_reg.snapshot && st_reg.cap_frame && !embedded && !wr_in
            && !frame_lvl_w && st_reg.frame_act;
    endsequence

    sequence s_wild_start;
        embedded && (line_start_code == CPC_CODE_WILD) && !st_reg.frame_act
            && code_hit && (code == line_start_code) && !is_fec && !wr_in;
    endsequence

    property p_irq_or;
        1'b1 |=> (camera_global_irq_out == $past(mis_any));
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("global interrupt differs from masked flags");

    property p_fec_clears;
        (embedded && is_fec && !wr_in) |=> !st_reg.frame_act ##1
            (!st_reg.frame_act || $past(is_fsc || is_lsc));
    endproperty
    a_fec_clears: assert property (p_fec_clears)
        else $error("frame flag not cleared by frame end");

    property p_err_set;
        (embedded && is_lec && !st_reg.line_act && !wr_in)
            |=> st_reg.ris[CPC_IRQ_ERR];
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("order error not flagged");

    property p_fsync_idle;
        (!embedded && !st_reg.capture && !wr_in && !st_reg.frame_act
            && frame_lvl_w) |=> st_reg.ris[CPC_IRQ_FSYNC];
    endproperty
    a_fsync_idle: assert property (p_fsync_idle)
        else $error("frame sync flag missing while idle");

    property p_no_err_hw;
        (!embedded && !st_reg.ris[CPC_IRQ_ERR] && !wr_in)
            |=> !st_reg.ris[CPC_IRQ_ERR];
    endproperty
    a_no_err_hw: assert property (p_no_err_hw)
        else $error("order error raised in hardware sync mode");

    property p_snap_stop;
        s_snap_end |=> !st_reg.capture && st_reg.ris[CPC_IRQ_FRAME];
    endproperty
    a_snap_stop: assert property (p_snap_stop)
        else $error("snapshot did not stop after one frame");

    property p_mis_read;
        (rd_in && addr_in == CPC_OFS_MIS)
            |=> rdata_out[CPC_IRQ_N-1:0] == $past(mis);
    endproperty
    a_mis_read: assert property (p_mis_read)
        else $error("masked status read is wrong");

    property p_wild_start;
        s_wild_start |=> st_reg.frame_act && st_reg.line_act;
    endproperty
    a_wild_start: assert property (p_wild_start)
        else $error("wildcard line start did not open frame");

    property p_marker_dropped;
        code_hit |-> !mk_pv;
    endproperty
    a_marker_dropped: assert property (p_marker_dropped)
        else $error("marker byte passed on as pixel");
endmodule : cpc_capture
`default_nettype wire

// ===== hdl/cpc_marker.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_marker (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [7:0] byte_in,
    input wire logic strobe_in,
    output logic code_hit_out,
    output logic [7:0] code_out,
    output logic pix_valid_out,
    output logic [7:0] pix_out
);
    import cpc_pkg::*;

    typedef struct packed {
        logic [2:0][7:0] hist;
        logic [2:0] hv;
        logic hit;
        logic [7:0] code;
        logic pv;
        logic [7:0] pix;
    } cpc_mark_t;

    cpc_mark_t st_reg;
    cpc_mark_t st_next;
    logic match;

    // four consecutive bytes form a marker
    assign match = (st_reg.hv == 3'h7) && (st_reg.hist[2] == CPC_MARK_FF)
        && (st_reg.hist[1] == CPC_MARK_00)
        && (st_reg.hist[0] == CPC_MARK_00);

    always_comb begin
        st_next = st_reg;
        st_next.hit = 1'b0;
        st_next.pv = 1'b0;
        if (strobe_in) begin
            if (match) begin
                // marker bytes never leave as pixels
                st_next.hit = 1'b1;
                st_next.code = byte_in;
                st_next.hv = 3'h0;
            end else begin
                // three-byte delay so a preamble can still be withdrawn
                st_next.pv = st_reg.hv[2];
                st_next.pix = st_reg.hist[2];
                st_next.hist = {st_reg.hist[1:0], byte_in};
                st_next.hv = {st_reg.hv[1:0], 1'b1};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign code_hit_out = st_reg.hit;
    assign code_out = st_reg.code;
    assign pix_valid_out = st_reg.pv;
    assign pix_out = st_reg.pix;
endmodule : cpc_marker
`default_nettype wire

// ===== hdl/cpc_pkg.sv
package cpc_pkg;
    localparam int CPC_ADDR_W = 8;
    localparam int CPC_DATA_W = 14;
    localparam int CPC_SYNC_W = CPC_DATA_W + 3;
    localparam int CPC_IRQ_N = 5;
    // register byte offsets
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_CTRL = 8'h00;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_STATUS = 8'h04;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_RIS = 8'h08;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_IER = 8'h0c;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_MIS = 8'h10;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_ICR = 8'h14;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_CODES = 8'h18;
    localparam logic [CPC_ADDR_W-1:0] CPC_OFS_DATA = 8'h1c;
    // control register fields
    localparam int CPC_CTRL_CAPTURE = 0;
    localparam int CPC_CTRL_SNAPSHOT = 1;
    localparam int CPC_CTRL_SYNC_SRC = 4;
    localparam int CPC_CTRL_EDGE = 5;
    localparam int CPC_CTRL_LPOL = 6;
    localparam int CPC_CTRL_FPOL = 7;
    localparam int CPC_CTRL_WIDTH = 10;
    localparam int CPC_CTRL_ENABLE = 14;
    // status register fields
    localparam int CPC_STAT_LINE = 0;
    localparam int CPC_STAT_FRAME = 1;
    localparam int CPC_STAT_DMA = 2;
    // interrupt source bits
    localparam int CPC_IRQ_FRAME = 0;
    localparam int CPC_IRQ_OVR = 1;
    localparam int CPC_IRQ_ERR = 2;
    localparam int CPC_IRQ_FSYNC = 3;
    localparam int CPC_IRQ_LINE = 4;
    // code byte lanes in the sync code register
    localparam int CPC_FEC_LSB = 24;
    localparam int CPC_LEC_LSB = 16;
    localparam int CPC_LSC_LSB = 8;
    localparam int CPC_FSC_LSB = 0;
    localparam logic [31:0] CPC_CODES_RST = 32'h0000_0000;
    // marker preamble and the wildcard code value
    localparam logic [7:0] CPC_MARK_FF = 8'hff;
    localparam logic [7:0] CPC_MARK_00 = 8'h00;
    localparam logic [7:0] CPC_CODE_WILD = 8'hff;
    // extended width encodings and sample masks
    localparam logic [1:0] CPC_W8 = 2'h0;
    localparam logic [1:0] CPC_W10 = 2'h1;
    localparam logic [1:0] CPC_W12 = 2'h2;
    localparam logic [13:0] CPC_MASK8 = 14'h00ff;
    localparam logic [13:0] CPC_MASK10 = 14'h03ff;
    localparam logic [13:0] CPC_MASK12 = 14'h0fff;
    localparam logic [13:0] CPC_MASK14 = 14'h3fff;
    localparam logic [1:0] CPC_BYTE_LAST = 2'h3;
endpackage : cpc_pkg

// ===== hdl/cpc_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_sync3 #(
    parameter int W = 1
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } cpc_sync_t;

    cpc_sync_t st_reg;
    cpc_sync_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // a change counts only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.stable[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stable_out = st_reg.stable;
endmodule : cpc_sync3
`default_nettype wire

// ===== test/cpc_camera_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_camera_model (
    output logic pclk_out,
    output logic [13:0] data_out,
    output logic lsync_out,
    output logic fsync_out
);
    initial begin
        pclk_out = 1'b0;
        data_out = 14'h0000;
        lsync_out = 1'b0;
        fsync_out = 1'b0;
    end
    task automatic put14(input logic [13:0] s);
        #7 data_out = s;
        #80 pclk_out = 1'b1;
        #160 pclk_out = 1'b0;
        #73;
        // hold over: lines no longer show the sample
        data_out = ~data_out;
    endtask : put14
    // upper lines carry junk in byte modes
    task automatic put(input logic [7:0] b);
        put14({~b[5:0], b});
    endtask : put
    task automatic mark(input logic [7:0] c);
        put(8'hff);
        put(8'h00);
        put(8'h00);
        put(c);
    endtask : mark
    task automatic idle(input logic pol);
        lsync_out = ~pol;
        fsync_out = ~pol;
        #640;
    endtask : idle
    task automatic frame(input logic pol, input logic wide,
        input logic [31:0] w);
        fsync_out = pol;
        #640 lsync_out = pol;
        #320;
        if (wide) begin
            put14(w[13:0]);
            put14(w[29:16]);
        end else begin
            for (int i = 0; i < 4; i++) put(w[8*i +: 8]);
        end
        #320 lsync_out = ~pol;
        #320 fsync_out = ~pol;
        #640;
    endtask : frame
endmodule : cpc_camera_model
`default_nettype wire

// ===== test/cpc_capture_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_capture_tb;
    import cpc_pkg::*;
    localparam logic [31:0] EN = 32'h1 << CPC_CTRL_ENABLE;
    localparam logic [31:0] CAP = 32'h1 << CPC_CTRL_CAPTURE;
    localparam logic [31:0] SNAP = 32'h1 << CPC_CTRL_SNAPSHOT;
    localparam logic [31:0] EMB = 32'h1 << CPC_CTRL_SYNC_SRC;
    localparam logic [31:0] RISE = 32'h1 << CPC_CTRL_EDGE;
    localparam logic [31:0] POL = 32'hc0;
    localparam logic [31:0] PIX = 32'hd4c3b2a1;
    localparam logic [31:0] W10 = {30'h0, CPC_W10} << CPC_CTRL_WIDTH;
    logic clk, srst, pclk, lsync, fsync, wr, rd, ack, req, irq;
    logic [13:0] data;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, word;
    int n_fail = 0;
    int samples_checked = 0;
    cpc_capture u_cpc_capture (.clock_in(clk), .srst_in(srst),
        .pixel_clock_in(pclk), .data_in(data), .line_sync_in(lsync),
        .frame_sync_in(fsync), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .dma_ack_in(ack),
        .dma_req_out(req), .dma_word_out(word),
        .camera_global_irq_out(irq));
    cpc_camera_model u_cpc_camera_model (.pclk_out(pclk),
        .data_out(data), .lsync_out(lsync), .fsync_out(fsync));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // settle first: flags land some clocks after the pins move
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        repeat (8) @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_reg
    task automatic take(input logic [31:0] exp);
        for (int i = 0; i < 400 && req !== 1'b1; i++) @(negedge clk);
        chk(word, exp);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
    endtask : take
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #400_000;
        n_fail++;
        close_out();
    end
    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        ack = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_reg(CPC_OFS_CODES, CPC_CODES_RST);
        wr_reg(CPC_OFS_CODES, 32'h9d1d8180);
        rd_reg(CPC_OFS_CODES, 32'h9d1d8180);
        rd_reg(8'h40, 32'h0);
        wr_reg(CPC_OFS_IER, 32'h1 << CPC_IRQ_FSYNC);
        wr_reg(CPC_OFS_CTRL, EN | RISE | POL);
        u_cpc_camera_model.frame(1'b1, 1'b0, 32'h0);
        rd_reg(CPC_OFS_RIS, 32'h1 << CPC_IRQ_FSYNC);
        chk({31'h0, irq}, 32'h1);
        rd_reg(CPC_OFS_MIS, 32'h1 << CPC_IRQ_FSYNC);
        wr_reg(CPC_OFS_ICR, 32'h1f);
        rd_reg(CPC_OFS_RIS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        u_cpc_camera_model.idle(1'b0);
        wr_reg(CPC_OFS_IER, 32'h1 << CPC_IRQ_FRAME);
        wr_reg(CPC_OFS_CTRL, EN | SNAP | CAP);
        u_cpc_camera_model.frame(1'b0, 1'b0, 32'h44332211);
        take(32'h44332211);
        rd_reg(CPC_OFS_CTRL, EN | SNAP);
        rd_reg(CPC_OFS_RIS, 32'h19);
        rd_reg(CPC_OFS_MIS, 32'h01);
        u_cpc_camera_model.frame(1'b0, 1'b0, PIX);
        chk({31'h0, req}, 32'h0);
        wr_reg(CPC_OFS_CTRL, EN | RISE | CAP | W10);
        u_cpc_camera_model.frame(1'b0, 1'b1, 32'h1def3abc);
        u_cpc_camera_model.frame(1'b0, 1'b1, 32'h0);
        take(32'h01ef02bc);
        rd_reg(CPC_OFS_CTRL, EN | RISE | CAP | W10);
        rd_reg(CPC_OFS_RIS, 32'h1b);
        wr_reg(CPC_OFS_ICR, 32'h1f);
        wr_reg(CPC_OFS_IER, 32'h1 << CPC_IRQ_ERR);
        wr_reg(CPC_OFS_CTRL, EN | RISE | EMB | CAP);
        u_cpc_camera_model.mark(8'h80);
        rd_reg(CPC_OFS_STATUS, 32'h2);
        u_cpc_camera_model.mark(8'h81);
        for (int i = 0; i < 4; i++) u_cpc_camera_model.put(PIX[8*i +: 8]);
        rd_reg(CPC_OFS_STATUS, 32'h3);
        u_cpc_camera_model.mark(8'h1d);
        take(PIX);
        rd_reg(CPC_OFS_STATUS, 32'h2);
        u_cpc_camera_model.mark(8'h9d);
        rd_reg(CPC_OFS_STATUS, 32'h0);
        u_cpc_camera_model.mark(8'h1d);
        rd_reg(CPC_OFS_RIS, 32'h1d);
        chk({31'h0, irq}, 32'h1);
        wr_reg(CPC_OFS_ICR, 32'h1f);
        wr_reg(CPC_OFS_CODES, 32'hff1d8180);
        u_cpc_camera_model.mark(8'h80);
        rd_reg(CPC_OFS_STATUS, 32'h2);
        u_cpc_camera_model.mark(8'h55);
        rd_reg(CPC_OFS_STATUS, 32'h0);
        wr_reg(CPC_OFS_CODES, 32'h9d1dff80);
        u_cpc_camera_model.mark(8'hff);
        rd_reg(CPC_OFS_STATUS, 32'h3);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_reg(CPC_OFS_CODES, CPC_CODES_RST);
        close_out();
    end
endmodule : cpc_capture_tb
`default_nettype wire
